// file: design/color_sensor_irq_status_regs.sv
// Overview of operation
// - reserved config bit 1 and status bits 15-4 read as zero.
// - two-bit field selects channel 0-3 for threshold compare; resets to 0.
// - direction bit: 0 makes interrupt pin input, 1 output; resets to 1.
// - mode: 0 alert on thresholds, 1 ready per channel, 3 ready after all.
// - burst bit, reset 1, advances read pointer after each register read.
// - overload status bit set when a conversion overflows.
// - conversion-ready bit set on completion, zero while converting.
// - ready bit cleared by reading status or writing it non-zero.
// - high flag set after fault-count consecutive results above high threshold.
// - low flag set after fault-count consecutive results below low threshold.
// - fault count field 0..3 demands 1, 2, 4 or 8 consecutive faults.
// - thresholds compare as four-bit exponent with twelve-bit mantissa.
// - polarity bit: 0 active low pin, 1 active high pin.
`timescale 1ns/1ns
module color_sensor_irq_status_regs
#(
    parameter logic [6:0] DEV_ADDR = 7'h44 // arbitrary
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic irq_pin_in,
    output logic irq_pin_out,
    output logic irq_pin_oe,
    output logic ext_trigger,
    input wire logic ch_result_valid,
    input wire logic [1:0] ch_result_index,
    input wire logic [15:0] ch_result,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conv_overflow,
    input wire logic [15:0] thr_high,
    input wire logic [15:0] thr_low,
    input wire logic [1:0] fault_count,
    input wire logic irq_pin_polarity,
    output logic [1:0] limit_channel_select
);
    // pin synchronisers; third stage only for edge detection
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic irq_s1, irq_s2, irq_s3;

    sensor_pkg::i2c_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] ptr_reg;
    logic [7:0] wr_hi_reg;
    logic [15:0] rd_word_reg;
    logic byte_lo_reg;
    logic nack_reg;
    logic sda_low_reg;
    logic wr_stb_reg;
    logic [7:0] wr_addr_reg;
    logic [15:0] wr_data_reg;
    logic rd_stb_reg;
    logic [7:0] rd_addr_reg;

    logic [15:0] cfg_reg;
    logic ovr_reg, rdy_reg, flag_hi_reg, flag_lo_reg;
    logic [7:0] irq_cnt_reg;
    logic irq_out_reg;

    limit_if lim();

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {irq_s1, irq_s2, irq_s3} <= 3'h7;
        end
        else
        begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
            {irq_s1, irq_s2, irq_s3} <= {irq_pin_in, irq_s1, irq_s2};
        end
    end

    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    wire busy = state_reg != sensor_pkg::ST_IDLE;

    // configuration fields
    wire burst_en = cfg_reg[sensor_pkg::CFG_BURST_BIT];
    wire pin_is_out = cfg_reg[sensor_pkg::CFG_DIR_BIT];
    wire [1:0] irq_mode = cfg_reg[sensor_pkg::CFG_MODE_LSB +: 2];
    wire [15:0] status_word = {12'h000, ovr_reg, rdy_reg, flag_hi_reg, flag_lo_reg};

    // read pointer for the next word: steps on after each completed word when the burst bit is set
    wire [7:0] rd_ptr = (state_reg == sensor_pkg::ST_RDATA && byte_lo_reg && burst_en)
                        ? 8'(ptr_reg + 8'h01) : ptr_reg;
    wire [15:0] rd_value = (rd_ptr == sensor_pkg::REG_CFG_OFFSET) ? cfg_reg & sensor_pkg::CFG_WMASK
                         : (rd_ptr == sensor_pkg::REG_STAT_OFFSET) ? status_word
                         : 16'h0000;
    wire addr_match = shift_reg[7:1] == DEV_ADDR;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= sensor_pkg::ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            wr_hi_reg <= 8'h00;
            rd_word_reg <= 16'h0000;
            byte_lo_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            wr_stb_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 16'h0000;
            rd_stb_reg <= 1'b0;
            rd_addr_reg <= 8'h00;
        end
        else
        begin
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            if (start_det)
            begin
                state_reg <= sensor_pkg::ST_ADDR;
                bit_cnt_reg <= 4'h0;
                byte_lo_reg <= 1'b0;
                sda_low_reg <= 1'b0;
            end
            else if (stop_det)
            begin
                state_reg <= sensor_pkg::ST_IDLE;
                sda_low_reg <= 1'b0;
            end
            else if (busy && scl_rise)
            begin
                if (bit_cnt_reg < 4'h8)
                begin
                    shift_reg <= {shift_reg[6:0], sda_s2};
                    tx_reg <= {tx_reg[6:0], 1'b0};
                end
                else
                begin
                    nack_reg <= sda_s2;
                end
                bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
            else if (busy && scl_fall && bit_cnt_reg == 4'h8)
            begin
                // acknowledge slot opens
                unique case (state_reg)
                    sensor_pkg::ST_ADDR:
                    begin
                        sda_low_reg <= addr_match;
                        if (!addr_match)
                        begin
                            state_reg <= sensor_pkg::ST_IDLE;
                        end
                    end
                    sensor_pkg::ST_PTR:
                    begin
                        ptr_reg <= shift_reg;
                        sda_low_reg <= 1'b1;
                    end
                    sensor_pkg::ST_WDATA:
                    begin
                        sda_low_reg <= 1'b1;
                        wr_hi_reg <= shift_reg;
                        wr_stb_reg <= byte_lo_reg;
                        wr_addr_reg <= ptr_reg;
                        wr_data_reg <= {wr_hi_reg, shift_reg};
                    end
                    sensor_pkg::ST_RDATA:
                    begin
                        sda_low_reg <= 1'b0;
                    end
                    sensor_pkg::ST_IDLE:
                    begin
                        sda_low_reg <= 1'b0;
                    end
                endcase
            end
            else if (busy && scl_fall && bit_cnt_reg == 4'h9)
            begin
                // acknowledge slot closes
                bit_cnt_reg <= 4'h0;
                sda_low_reg <= 1'b0;
                unique case (state_reg)
                    sensor_pkg::ST_ADDR:
                    begin
                        if (shift_reg[0])
                        begin
                            state_reg <= sensor_pkg::ST_RDATA;
                            rd_stb_reg <= 1'b1;
                            rd_addr_reg <= rd_ptr;
                            rd_word_reg <= rd_value;
                            tx_reg <= rd_value[15:8];
                            sda_low_reg <= ~rd_value[15];
                        end
                        else
                        begin
                            state_reg <= sensor_pkg::ST_PTR;
                        end
                    end
                    sensor_pkg::ST_PTR:
                    begin
                        state_reg <= sensor_pkg::ST_WDATA;
                        byte_lo_reg <= 1'b0;
                    end
                    sensor_pkg::ST_WDATA:
                    begin
                        byte_lo_reg <= ~byte_lo_reg;
                    end
                    sensor_pkg::ST_RDATA:
                    begin
                        if (nack_reg)
                        begin
                            state_reg <= sensor_pkg::ST_IDLE;
                        end
                        else if (!byte_lo_reg)
                        begin
                            byte_lo_reg <= 1'b1;
                            tx_reg <= rd_word_reg[7:0];
                            sda_low_reg <= ~rd_word_reg[7];
                        end
                        else
                        begin
                            byte_lo_reg <= 1'b0;
                            ptr_reg <= rd_ptr;
                            rd_stb_reg <= 1'b1;
                            rd_addr_reg <= rd_ptr;
                            rd_word_reg <= rd_value;
                            tx_reg <= rd_value[15:8];
                            sda_low_reg <= ~rd_value[15];
                        end
                    end
                    sensor_pkg::ST_IDLE:
                    begin
                        bit_cnt_reg <= 4'h0;
                    end
                endcase
            end
            else if (state_reg == sensor_pkg::ST_RDATA && scl_fall && bit_cnt_reg < 4'h8)
            begin
                sda_low_reg <= ~tx_reg[7];
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_low_reg;

    // register side effects
    wire cfg_wr = wr_stb_reg && wr_addr_reg == sensor_pkg::REG_CFG_OFFSET;
    wire stat_rd = rd_stb_reg && rd_addr_reg == sensor_pkg::REG_STAT_OFFSET;
    wire stat_wr_nz = wr_stb_reg && wr_addr_reg == sensor_pkg::REG_STAT_OFFSET
                      && wr_data_reg != 16'h0000;
    wire rdy_clr = conv_start || stat_rd || stat_wr_nz;
    // set wins over clear on every flag
    wire rdy_next = conv_done || (rdy_reg && !rdy_clr);
    wire ovr_next = conv_overflow || (ovr_reg && !stat_rd);
    wire hi_next = lim.hit_high || (flag_hi_reg && !stat_rd);
    wire lo_next = lim.hit_low || (flag_lo_reg && !stat_rd);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_reg <= sensor_pkg::CFG_RESET;
            {ovr_reg, rdy_reg, flag_hi_reg, flag_lo_reg} <= sensor_pkg::STAT_RESET[3:0];
        end
        else
        begin
            if (cfg_wr)
            begin
                cfg_reg <= wr_data_reg & sensor_pkg::CFG_WMASK;
            end
            ovr_reg <= ovr_next;
            rdy_reg <= rdy_next;
            flag_hi_reg <= hi_next;
            flag_lo_reg <= lo_next;
        end
    end

    assign limit_channel_select = cfg_reg[sensor_pkg::CFG_CHSEL_LSB +: 2];

    assign lim.sample_valid = ch_result_valid && ch_result_index == limit_channel_select;
    assign lim.sample = ch_result;
    assign lim.thr_high = thr_high;
    assign lim.thr_low = thr_low;
    assign lim.fault_sel = fault_count;

    limit_compare u_limit_compare
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .lim(lim.cmp)
    );

    // interrupt pin
    wire ready_event = (irq_mode == sensor_pkg::IRQ_EACH && ch_result_valid)
                       || (irq_mode == sensor_pkg::IRQ_ALL && conv_done);
    wire alert_level = irq_mode == sensor_pkg::IRQ_ALERT && (flag_hi_reg || flag_lo_reg);
    wire irq_active = alert_level || irq_cnt_reg != 8'h00;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_cnt_reg <= 8'h00;
            irq_out_reg <= 1'b1;
        end
        else
        begin
            if (ready_event)
            begin
                irq_cnt_reg <= 8'(sensor_pkg::IRQ_PULSE_CYCLES);
            end
            else if (irq_cnt_reg != 8'h00)
            begin
                irq_cnt_reg <= 8'(irq_cnt_reg - 8'h01);
            end
            irq_out_reg <= ~(irq_active ^ irq_pin_polarity);
        end
    end

    assign irq_pin_out = irq_out_reg;
    assign irq_pin_oe = pin_is_out;
    assign ext_trigger = ~pin_is_out && irq_s2 && !irq_s3;
endmodule // color_sensor_irq_status_regs

// file: design/sensor_pkg.sv
package sensor_pkg;
    // register pointer values
    localparam logic [7:0] REG_CFG_OFFSET = 8'h0B;
    localparam logic [7:0] REG_STAT_OFFSET = 8'h0C;
    // reset values
    localparam logic [15:0] CFG_RESET = 16'h8011;
    localparam logic [15:0] STAT_RESET = 16'h0000;
    // bit 1 of the config register is held at zero
    localparam logic [15:0] CFG_WMASK = 16'hFFFD;
    // config field positions
    localparam int CFG_TOP_LSB = 7;
    localparam int CFG_CHSEL_LSB = 5;
    localparam int CFG_DIR_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_BURST_BIT = 0;
    // status field positions
    localparam int STAT_OVR_BIT = 3;
    localparam int STAT_RDY_BIT = 2;
    localparam int STAT_HI_BIT = 1;
    localparam int STAT_LO_BIT = 0;
    // threshold / result word layout
    localparam int THR_EXP_LSB = 12;
    localparam int MANT_W = 12;
    localparam int EXP_W = 4;
    localparam int WIDE_W = 27;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_PULSE_NS = 1000;
    localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        IRQ_ALERT = 2'b00,
        IRQ_EACH = 2'b01,
        IRQ_RSV = 2'b10,
        IRQ_ALL = 2'b11
    } irq_mode_t;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } i2c_state_t;
endpackage

// file: design/limit_if.sv
`timescale 1ns/1ns
interface limit_if;
    logic sample_valid;
    logic [15:0] sample;
    logic [15:0] thr_high;
    logic [15:0] thr_low;
    logic [1:0] fault_sel;
    logic hit_high;
    logic hit_low;
    modport src
    (
        output sample_valid, sample, thr_high, thr_low, fault_sel,
        input hit_high, hit_low
    );
    modport cmp
    (
        input sample_valid, sample, thr_high, thr_low, fault_sel,
        output hit_high, hit_low
    );
endinterface

// file: design/limit_compare.sv
`timescale 1ns/1ns
module limit_compare
(
    input wire logic clk,
    input wire logic sys_rst,
    limit_if.cmp lim
);
    // mantissa shifted by exponent gives a plain magnitude
    function automatic logic [sensor_pkg::WIDE_W-1:0] expand(input logic [15:0] v);
        logic [sensor_pkg::WIDE_W-1:0] m;
        m = {{(sensor_pkg::WIDE_W-sensor_pkg::MANT_W){1'b0}}, v[sensor_pkg::MANT_W-1:0]};
        expand = m << v[sensor_pkg::THR_EXP_LSB +: sensor_pkg::EXP_W];
    endfunction

    logic [3:0] hi_cnt_reg;
    logic [3:0] lo_cnt_reg;
    logic hit_high_reg;
    logic hit_low_reg;

    wire above = expand(lim.sample) > expand(lim.thr_high);
    wire below = expand(lim.sample) < expand(lim.thr_low);
    wire [3:0] need = 4'h1 << lim.fault_sel;
    wire [3:0] hi_cnt_next = (hi_cnt_reg >= need) ? need : 4'(hi_cnt_reg + 4'h1);
    wire [3:0] lo_cnt_next = (lo_cnt_reg >= need) ? need : 4'(lo_cnt_reg + 4'h1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hi_cnt_reg <= 4'h0;
            lo_cnt_reg <= 4'h0;
            hit_high_reg <= 1'b0;
            hit_low_reg <= 1'b0;
        end
        else
        begin
            hit_high_reg <= lim.sample_valid && above && (hi_cnt_next >= need);
            hit_low_reg <= lim.sample_valid && below && (lo_cnt_next >= need);
            if (lim.sample_valid)
            begin
                hi_cnt_reg <= above ? hi_cnt_next : 4'h0;
                lo_cnt_reg <= below ? lo_cnt_next : 4'h0;
            end
        end
    end

    assign lim.hit_high = hit_high_reg;
    assign lim.hit_low = hit_low_reg;
endmodule // limit_compare

// file: sim/i2c_host_model.sv
`timescale 1ns/1ns
module i2c_host_model
(
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // also serves as repeated start after an ack slot
    task automatic start_c();
        w(2);
        sda_m = 1'b1;
        w(4);
        scl = 1'b1;
        w(8);
        sda_m = 1'b0;
        w(8);
        scl = 1'b0;
    endtask
    task automatic stop_c();
        w(2);
        sda_m = 1'b0;
        w(6);
        scl = 1'b1;
        w(8);
        sda_m = 1'b1;
        w(8);
    endtask
    // data set a quarter into the low phase, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_m = b;
        w(6);
        scl = 1'b1;
        w(4);
        r = sda;
        w(4);
        scl = 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic a_in, output logic [7:0] q,
        output logic a_out);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(a_in, a_out);
    endtask
    task automatic xfer_w(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
        output integer nk);
        logic [7:0] q;
        logic ak;
        start_c();
        byte_x({a, 1'b0}, 1'b1, q, ak);
        nk = integer'(ak);
        byte_x(p, 1'b1, q, ak);
        nk += integer'(ak);
        byte_x(d[15:8], 1'b1, q, ak);
        nk += integer'(ak);
        byte_x(d[7:0], 1'b1, q, ak);
        nk += integer'(ak);
        stop_c();
    endtask
    task automatic xfer_r(input logic [6:0] a, input logic [7:0] p, input int n,
        output logic [31:0] q, output integer nk);
        logic [7:0] b;
        logic ak;
        q = 32'h0000_0000;
        start_c();
        byte_x({a, 1'b0}, 1'b1, b, ak);
        nk = integer'(ak);
        byte_x(p, 1'b1, b, ak);
        nk += integer'(ak);
        start_c();
        byte_x({a, 1'b1}, 1'b1, b, ak);
        nk += integer'(ak);
        for (int k = 0; k < 2 * n; k++)
        begin
            byte_x(8'hFF, k == 2 * n - 1, b, ak);
            q = {q[23:0], b};
        end
        stop_c();
    endtask
endmodule // i2c_host_model

// file: sim/color_sensor_irq_status_regs_monitor.sv
`timescale 1ns/1ns
module color_sensor_irq_status_regs_monitor
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic irq_pin_in,
    input wire logic sda_oe,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe,
    input wire logic ext_trigger,
    input wire logic ch_result_valid,
    input wire logic conv_done,
    input wire logic irq_pin_polarity,
    input wire logic [1:0] limit_channel_select
);
    logic [7:0] ev_hist_reg;
    logic [1:0] pol_hist_reg;
    wire act = irq_pin_out == irq_pin_polarity;
    wire pol_steady = pol_hist_reg == {2{irq_pin_polarity}};
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            ev_hist_reg <= 8'h00;
        else
            ev_hist_reg <= {ev_hist_reg[6:0], ch_result_valid | conv_done};
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            pol_hist_reg <= 2'h0;
        else
            pol_hist_reg <= {pol_hist_reg[0], irq_pin_polarity};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    reset_value_a: assert property ($fell(sys_rst) |-> irq_pin_oe && limit_channel_select == 2'h0)
        else $error("config outputs wrong after reset");
    irq_reset_a: assert property ($fell(sys_rst) |-> ##1 irq_pin_out == !irq_pin_polarity)
        else $error("interrupt pin not inactive after reset");
    ext_single_a: assert property (ext_trigger |=> !ext_trigger)
        else $error("trigger pulse longer than one cycle");
    ext_input_a: assert property (ext_trigger |-> !irq_pin_oe)
        else $error("trigger while pin is an output");
    ext_cause_a: assert property (ext_trigger |-> $past(irq_pin_in, 2) && !$past(irq_pin_in, 3))
        else $error("trigger without rising pin");
    cfg_timing_a: assert property ($changed(limit_channel_select) || $changed(irq_pin_oe) |-> !scl_in)
        else $error("config changed outside a write slot");
    sda_timing_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    irq_cause_a: assert property ($rose(act) && pol_steady |-> ev_hist_reg != 8'h00)
        else $error("interrupt raised without an event");
    cover property (ext_trigger);
    cover property ($rose(act));
    cover property ($changed(limit_channel_select));
endmodule // color_sensor_irq_status_regs_monitor
bind color_sensor_irq_status_regs color_sensor_irq_status_regs_monitor
    color_sensor_irq_status_regs_monitor_i
(
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .irq_pin_in(irq_pin_in), .sda_oe(sda_oe),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe), .ext_trigger(ext_trigger),
    .ch_result_valid(ch_result_valid), .conv_done(conv_done),
    .irq_pin_polarity(irq_pin_polarity), .limit_channel_select(limit_channel_select)
);

// file: sim/color_sensor_irq_status_regs_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module color_sensor_irq_status_regs_tb_top;
    localparam logic [6:0] ADDR = 7'h44;
    logic clk, sys_rst, scl, sda_m, irq_drv, ch_result_valid, conv_start, conv_done;
    logic conv_overflow, irq_pin_polarity, sda_out, sda_oe, irq_pin_out, irq_pin_oe;
    logic ext_trigger;
    logic [1:0] ch_result_index, fault_count, limit_channel_select;
    logic [15:0] ch_result, thr_high, thr_low;
    logic [31:0] q;
    int errors = 0;
    int n_checks = 0;
    integer nk;
    int tc0;
    int trig_cnt = 0;
    // open-drain data line with pull-up; interrupt line driven by the pin when it is an output, else by irq_drv
    wire sda = sda_m & ~(sda_oe & ~sda_out);
    wire irq_wire = irq_pin_oe ? irq_pin_out : irq_drv;
    color_sensor_irq_status_regs #(.DEV_ADDR(ADDR)) color_sensor_irq_status_regs_i
    (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .irq_pin_in(irq_wire), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .ext_trigger(ext_trigger),
        .ch_result_valid(ch_result_valid), .ch_result_index(ch_result_index),
        .ch_result(ch_result), .conv_start(conv_start), .conv_done(conv_done),
        .conv_overflow(conv_overflow), .thr_high(thr_high), .thr_low(thr_low),
        .fault_count(fault_count), .irq_pin_polarity(irq_pin_polarity),
        .limit_channel_select(limit_channel_select)
    );
    i2c_host_model i2c_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    function automatic logic [15:0] cfg(input logic [1:0] ch, input logic dir,
        input logic [1:0] md, input logic bst);
        return {9'h100, ch, dir, md, 1'b0, bst};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        i2c_host_model_i.xfer_w(ADDR, p, d, nk);
        `CHK(nk, 0)
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        i2c_host_model_i.xfer_r(ADDR, p, n, q, nk);
        `CHK(nk, 0)
    endtask
    task automatic result(input logic [1:0] ix, input logic [15:0] v, input int n);
        repeat (n)
        begin
            @(negedge clk);
            {ch_result_valid, ch_result_index, ch_result} = {1'b1, ix, v};
            @(negedge clk);
            ch_result_valid = 1'b0;
        end
    endtask
    // k selects start, done or overflow
    task automatic pulse(input int k);
        @(negedge clk);
        {conv_overflow, conv_done, conv_start} = 3'h1 << k;
        @(negedge clk);
        {conv_overflow, conv_done, conv_start} = 3'h0;
    endtask
    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk)
        if (ext_trigger === 1'b1)
            trig_cnt++;
    initial
    begin
        #600000;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    initial
    begin
        {sys_rst, irq_drv, ch_result_valid, conv_start, conv_done, conv_overflow} = 6'h20;
        {ch_result_index, fault_count, irq_pin_polarity, ch_result} = 21'h000000;
        thr_high = 16'h1800;
        thr_low = 16'h1400;
        cyc(10);
        sys_rst = 1'b0;
        cyc(5);
        `CHK(limit_channel_select, 2'h0)
        `CHK(irq_pin_oe, 1'b1)
        rd(8'h0B, 2);
        `CHK(q, 32'h8011_0000)
        tend("reset");
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h0B, cfg(c[1:0], 1'b1, c[1:0], 1'b1));
            rd(8'h0B, 1);
            `CHK(q[15:0], cfg(c[1:0], 1'b1, c[1:0], 1'b1))
            `CHK(limit_channel_select, c[1:0])
        end
        wr(8'h0B, cfg(2'h1, 1'b1, 2'h0, 1'b0));
        rd(8'h0B, 2);
        `CHK(q, {2{cfg(2'h1, 1'b1, 2'h0, 1'b0)}})
        rd(8'h05, 1);
        `CHK(q[15:0], 16'h0000)
        i2c_host_model_i.xfer_w(7'h23, 8'h0B, 16'h8000, nk);
        `CHK(nk, 4)
        `CHK(limit_channel_select, 2'h1)
        tend("config");
        wr(8'h0B, cfg(2'h0, 1'b0, 2'h0, 1'b1));
        `CHK(irq_pin_oe, 1'b0)
        tc0 = trig_cnt;
        cyc(10);
        irq_drv = 1'b1;
        cyc(10);
        irq_drv = 1'b0;
        cyc(5);
        `CHK(trig_cnt, tc0 + 1)
        tend("direction");
        wr(8'h0B, cfg(2'h2, 1'b1, 2'h0, 1'b1));
        pulse(1);
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0004)
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0000)
        pulse(2);
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0008)
        pulse(1);
        wr(8'h0C, 16'h0004);
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0000)
        pulse(1);
        pulse(0);
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0000)
        tend("status");
        irq_pin_polarity = 1'b1;
        for (int f = 0; f < 4; f++)
        begin
            fault_count = f[1:0];
            result(2'h2, 16'h0C00, 1);
            result(2'h1, 16'h2401, 8);
            result(2'h2, 16'h2401, (1 << f) - 1);
            cyc(6);
            `CHK(irq_pin_out, 1'b0)
            result(2'h2, 16'h2401, 1);
            cyc(6);
            `CHK(irq_pin_out, 1'b1)
            rd(8'h0C, 1);
            `CHK(q[15:0], 16'h0002)
            `CHK(irq_pin_out, 1'b0)
        end
        irq_pin_polarity = 1'b0;
        result(2'h2, 16'h1400, 8);
        cyc(6);
        `CHK(irq_pin_out, 1'b1)
        result(2'h2, 16'h07FF, 8);
        cyc(6);
        `CHK(irq_pin_out, 1'b0)
        rd(8'h0C, 1);
        `CHK(q[15:0], 16'h0001)
        tend("limits");
        irq_pin_polarity = 1'b1;
        wr(8'h0B, cfg(2'h2, 1'b1, 2'h1, 1'b1));
        result(2'h0, 16'h0C00, 1);
        cyc(5);
        `CHK(irq_pin_out, 1'b1)
        cyc(110);
        `CHK(irq_pin_out, 1'b0)
        wr(8'h0B, cfg(2'h2, 1'b1, 2'h3, 1'b1));
        result(2'h0, 16'h0C00, 1);
        cyc(10);
        `CHK(irq_pin_out, 1'b0)
        pulse(1);
        cyc(5);
        `CHK(irq_pin_out, 1'b1)
        tend("modes");
        tally_and_finish();
    end
endmodule // color_sensor_irq_status_regs_tb_top
